/* srp_regs.vh */
// Register map, instruction fields and reset values of the serial register port
`ifndef SRP_REGS_VH
`define SRP_REGS_VH

`define SRP_ADDR_GAIN_B_LO 5'h18
`define SRP_ADDR_GAIN_HI 5'h19
`define SRP_ADDR_FACTORY 5'h1A
`define SRP_ADDR_TEST_CLK 5'h1B
`define SRP_ADDR_STROBE_CFG 5'h1C
`define SRP_ADDR_CFG_MSB 5'h00
`define SRP_ADDR_RSVD_LO 5'h1D

`define SRP_RST_GAIN_B_LO 8'h00
`define SRP_RST_GAIN_HI 8'hFF
`define SRP_RST_FACTORY 8'h00
`define SRP_RST_TEST_CLK 8'h00
`define SRP_RST_STROBE_CFG 8'h00
`define SRP_RST_CFG 8'h00
`define SRP_READ_ZERO 8'h00
`define SRP_RST_GAIN_A_WORD 12'hFFF
`define SRP_RST_GAIN_B_WORD 12'hF00
`define SRP_GAIN_A_PAD 8'h00
`define SRP_GAIN_A_HI 7
`define SRP_GAIN_A_LO 4
`define SRP_GAIN_B_HI 3

`define SRP_INS_RW 7
`define SRP_INS_CNT_HI 6
`define SRP_INS_CNT_LO 5
`define SRP_INS_ADDR_HI 4

`define SRP_CFG_FOUR_WIRE 0
`define SRP_TEST_CODE_HI 7
`define SRP_TEST_CODE_LO 3
`define SRP_TEST_PHASE_HI 2
`define SRP_TEST_PHASE_LO 1
`define SRP_STROBE_SEL_BIT 0

`define SRP_CODE_DIV1 5'h1D
`define SRP_CODE_DIV2 5'h1E
`define SRP_CODE_DIV4 5'h1F

`define SRP_BIT_LAST 3'h7
`define SRP_BIT_FIRST 3'h0
`define SRP_BYTE_MAX 2'h3

`endif

/* srp_serial_port.v */
// Serial register port: frame decode, register file and derived controls
// ****************************************************************
// Behaviour
// [R01] Port runs 3-pin or 4-pin per a configuration register bit.
// [R02] In 3-pin form the data pin carries both host and read data.
// [R03] Host holds frame enable low for one instruction plus 1-4 data bytes.
// [R04] Instruction bit 7 high reads, low writes.
// [R05] Instruction bits 6:5 give data byte count minus one.
// [R06] All bytes shift most significant bit first.
// [R07] Low five instruction bits give the first register address.
// [R08] Each further data byte accesses the next register address.
// [R09] Data in sampled on rising serial clock while frame enable is low.
// [R10] 3-pin read drives the data pin; separate output floats.
// [R11] 4-pin read drives the dedicated output pin.
// [R12] Read data changes on falling serial clock edges.
// [R13] After last read bit output drives low until frame end, then floats; the 3-pin data pin floats at once.
// [R14] Addresses 0x1D-0x1F ignore writes and read 0x00.
// [R15] Register 0x18 holds channel B gain bits 7:0.
// [R16] Register 0x19 holds both gain nibbles, reset 0xFF.
// [R17] Test codes 11101/11110/11111 route clock, /2, /4 to lock pin; code routes them only while pll_enabled_i is high, else lock pin stays low.
// [R18] Two-bit test field sets coarse mixer initial phase after strobe.
// [R19] Strobe select bit picks full-rate or divided latch clock.
// [R20] Register 0x1A is factory reserved, reset 0x00.
// [R21] Enabled strobe rising edge clears oscillator phase accumulator.
// ****************************************************************
`timescale 1ns/10ps
`include "srp_regs.vh"

module srp_serial_port #(
	parameter DW = 8
) (
	input wire clk_sys_i,
	input wire reset_n_i,
	input wire ser_clk_i,
	input wire frame_enable_n_i,
	input wire ser_data_io_i,
	input wire pll_enabled_i,
	input wire phase_strobe_i,
	input wire nco_sync_enable_i,
	input wire full_rate_tick_i,
	input wire div_clock_tick_i,
	input wire conv_clock_i,
	output reg ser_data_io_o,
	output reg ser_data_io_oe_o,
	output reg ser_data_out_o,
	output reg ser_data_out_oe_o,
	output reg [11:0] gain_a_o,
	output reg [11:0] gain_b_o,
	output reg [7:0] factory_clock_o,
	output reg lock_pin_o,
	output reg lock_pin_test_o,
	output reg [1:0] mixer_phase_o,
	output reg mixer_phase_load_o,
	output reg strobe_latched_o,
	output reg nco_acc_clear_o,
	output reg four_wire_select_o
);

// ****************************************************************
// Register storage
// ****************************************************************
reg [DW-1:0] gain_b_lo_reg;
reg [DW-1:0] gain_hi_reg;
reg [DW-1:0] factory_reg;
reg [DW-1:0] test_clk_reg;
reg [DW-1:0] strobe_cfg_reg;
reg [DW-1:0] cfg_msb_reg;

// ****************************************************************
// Serial clock edges, in system clock domain
// ****************************************************************
reg sclk_d_reg;
wire sclk_rise = ser_clk_i & ~sclk_d_reg;
wire sclk_fall = ~ser_clk_i & sclk_d_reg;
wire in_frame = ~frame_enable_n_i;

reg [2:0] bit_cnt_reg;
reg [1:0] byte_cnt_reg;
reg instr_done_reg;
reg read_reg;
reg [1:0] count_reg;
reg [4:0] addr_reg;
reg [DW-1:0] shift_in_reg;
reg [DW-1:0] shift_out_reg;
reg rd_active_reg;
reg rd_done_reg;
reg frame_over_reg;

wire [DW-1:0] rx_byte = {shift_in_reg[DW-2:0], ser_data_io_i};
wire bit_take = sclk_rise & in_frame & ~frame_over_reg;
wire byte_end = bit_take & (bit_cnt_reg == `SRP_BIT_LAST);
wire instr_end = byte_end & ~instr_done_reg;
wire data_end = byte_end & instr_done_reg;
wire wr_take = data_end & ~read_reg;
wire rd_fall = in_frame & rd_active_reg & sclk_fall & ~rd_done_reg & instr_done_reg;

function [DW-1:0] srp_read;
	input [4:0] a;
	begin
		case (a)
			`SRP_ADDR_GAIN_B_LO: srp_read = gain_b_lo_reg; // [R15]
			`SRP_ADDR_GAIN_HI: srp_read = gain_hi_reg; // [R16]
			`SRP_ADDR_FACTORY: srp_read = factory_reg; // [R20]
			`SRP_ADDR_TEST_CLK: srp_read = test_clk_reg;
			`SRP_ADDR_STROBE_CFG: srp_read = strobe_cfg_reg;
			`SRP_ADDR_CFG_MSB: srp_read = cfg_msb_reg; // [R01]
			default: srp_read = `SRP_READ_ZERO; // [R14]
		endcase
	end
endfunction

// ****************************************************************
// Serial clock edge capture
// ****************************************************************
always @(posedge clk_sys_i or negedge reset_n_i)
begin
	if (!reset_n_i)
		sclk_d_reg <= 1'b0;
	else
		sclk_d_reg <= ser_clk_i;
end

// ****************************************************************
// Bit and byte counters
// ****************************************************************
always @(posedge clk_sys_i or negedge reset_n_i)
begin
	if (!reset_n_i)
	begin
		bit_cnt_reg <= `SRP_BIT_FIRST;
		byte_cnt_reg <= 2'h0;
		frame_over_reg <= 1'b0;
	end
	else if (!in_frame)
	begin
		// Frame end always restarts the decoder, even mid-byte
		bit_cnt_reg <= `SRP_BIT_FIRST;
		byte_cnt_reg <= 2'h0;
		frame_over_reg <= 1'b0;
	end
	else
	begin
		if (bit_take)
			bit_cnt_reg <= bit_cnt_reg + 3'h1;
		if (data_end)
		begin
			byte_cnt_reg <= byte_cnt_reg + 2'h1;
			// Bits after the counted bytes are ignored until frame end
			if (byte_cnt_reg == count_reg)
				frame_over_reg <= 1'b1; // [R05]
		end
	end
end

// ****************************************************************
// Input shift register
// ****************************************************************
always @(posedge clk_sys_i or negedge reset_n_i)
begin
	if (!reset_n_i)
		shift_in_reg <= {DW{1'b0}};
	else if (bit_take)
		shift_in_reg <= rx_byte; // [R09] [R06]
end

// ****************************************************************
// Instruction decode and address stepping
// ****************************************************************
always @(posedge clk_sys_i or negedge reset_n_i)
begin
	if (!reset_n_i)
	begin
		instr_done_reg <= 1'b0;
		read_reg <= 1'b0;
		count_reg <= 2'h0;
		addr_reg <= 5'h00;
		rd_active_reg <= 1'b0;
	end
	else if (!in_frame)
	begin
		instr_done_reg <= 1'b0;
		rd_active_reg <= 1'b0;
	end
	else if (instr_end)
	begin
		instr_done_reg <= 1'b1;
		read_reg <= rx_byte[`SRP_INS_RW]; // [R04]
		count_reg <= rx_byte[`SRP_INS_CNT_HI:`SRP_INS_CNT_LO]; // [R05]
		addr_reg <= rx_byte[`SRP_INS_ADDR_HI:0]; // [R07]
		rd_active_reg <= rx_byte[`SRP_INS_RW]; // [R04]
	end
	else if (data_end)
		addr_reg <= addr_reg + 5'h01; // [R08]
end

// ****************************************************************
// Register writes
// ****************************************************************
always @(posedge clk_sys_i or negedge reset_n_i)
begin
	if (!reset_n_i)
	begin
		gain_b_lo_reg <= `SRP_RST_GAIN_B_LO;
		gain_hi_reg <= `SRP_RST_GAIN_HI;
		factory_reg <= `SRP_RST_FACTORY;
		test_clk_reg <= `SRP_RST_TEST_CLK;
		strobe_cfg_reg <= `SRP_RST_STROBE_CFG;
		cfg_msb_reg <= `SRP_RST_CFG;
	end
	else if (wr_take)
	begin
		case (addr_reg)
			`SRP_ADDR_GAIN_B_LO: gain_b_lo_reg <= rx_byte; // [R15]
			`SRP_ADDR_GAIN_HI: gain_hi_reg <= rx_byte; // [R16]
			// Factory register kept writable but should stay at default
			`SRP_ADDR_FACTORY: factory_reg <= rx_byte; // [R20]
			`SRP_ADDR_TEST_CLK: test_clk_reg <= rx_byte;
			`SRP_ADDR_STROBE_CFG: strobe_cfg_reg <= rx_byte;
			`SRP_ADDR_CFG_MSB: cfg_msb_reg <= rx_byte; // [R01]
			// Reserved and foreign addresses leave every register untouched
			default: cfg_msb_reg <= cfg_msb_reg; // [R14]
		endcase
	end
end

// ****************************************************************
// Read shifter
// ****************************************************************
always @(posedge clk_sys_i or negedge reset_n_i)
begin
	if (!reset_n_i)
	begin
		shift_out_reg <= {DW{1'b0}};
		rd_done_reg <= 1'b0;
	end
	else if (!in_frame)
		rd_done_reg <= 1'b0;
	else if (rd_fall)
	begin
		// Loading on a fall too keeps byte boundaries off the rising edge
		if (frame_over_reg)
			rd_done_reg <= 1'b1; // [R13]
		else if (bit_cnt_reg == `SRP_BIT_FIRST)
			shift_out_reg <= srp_read(addr_reg); // [R12] [R08]
		else
			shift_out_reg <= {shift_out_reg[DW-2:0], 1'b0}; // [R12] [R06]
	end
end

// ****************************************************************
// Serial output pins
// ****************************************************************
wire four_wire = cfg_msb_reg[`SRP_CFG_FOUR_WIRE];
wire drive_rd = in_frame & rd_active_reg;
wire rd_bit = rd_done_reg ? 1'b0 : shift_out_reg[DW-1];

always @(posedge clk_sys_i or negedge reset_n_i)
begin
	if (!reset_n_i)
	begin
		ser_data_io_o <= 1'b0;
		ser_data_io_oe_o <= 1'b0;
		ser_data_out_o <= 1'b0;
		ser_data_out_oe_o <= 1'b0;
		four_wire_select_o <= 1'b0;
	end
	else
	begin
		four_wire_select_o <= four_wire; // [R01]
		ser_data_io_o <= rd_bit; // [R02]
		ser_data_io_oe_o <= drive_rd & ~four_wire & ~rd_done_reg; // [R10]
		ser_data_out_o <= rd_bit; // [R11] [R13]
		ser_data_out_oe_o <= drive_rd & four_wire; // [R11] [R13]
	end
end

// ****************************************************************
// Derived controls
// ****************************************************************
wire [4:0] test_code = test_clk_reg[`SRP_TEST_CODE_HI:`SRP_TEST_CODE_LO];
reg [1:0] conv_div_reg;
reg conv_d_reg;
reg strobe_d_reg;
wire latch_tick = strobe_cfg_reg[`SRP_STROBE_SEL_BIT] ? full_rate_tick_i : div_clock_tick_i;
wire strobe_rise = phase_strobe_i & ~strobe_d_reg;

always @(posedge clk_sys_i or negedge reset_n_i)
begin
	if (!reset_n_i)
	begin
		gain_a_o <= `SRP_RST_GAIN_A_WORD;
		gain_b_o <= `SRP_RST_GAIN_B_WORD;
		factory_clock_o <= `SRP_RST_FACTORY;
		mixer_phase_o <= 2'h0;
		mixer_phase_load_o <= 1'b0;
		strobe_latched_o <= 1'b0;
		strobe_d_reg <= 1'b0;
		nco_acc_clear_o <= 1'b0;
	end
	else
	begin
		// Channel A low byte lives outside this block; reset loads it as 0xFF, after that it is driven zero here
		gain_a_o <= {gain_hi_reg[`SRP_GAIN_A_HI:`SRP_GAIN_A_LO], `SRP_GAIN_A_PAD}; // [R16]
		gain_b_o <= {gain_hi_reg[`SRP_GAIN_B_HI:0], gain_b_lo_reg}; // [R15] [R16]
		factory_clock_o <= factory_reg; // [R20]
		if (latch_tick)
			strobe_latched_o <= phase_strobe_i; // [R19]
		strobe_d_reg <= phase_strobe_i;
		mixer_phase_load_o <= strobe_rise; // [R18]
		mixer_phase_o <= test_clk_reg[`SRP_TEST_PHASE_HI:`SRP_TEST_PHASE_LO]; // [R18]
		nco_acc_clear_o <= nco_sync_enable_i & strobe_rise; // [R21]
	end
end

// ****************************************************************
// Test clock routing
// ****************************************************************
always @(posedge clk_sys_i or negedge reset_n_i)
begin
	if (!reset_n_i)
	begin
		conv_d_reg <= 1'b0;
		conv_div_reg <= 2'h0;
		lock_pin_o <= 1'b0;
		lock_pin_test_o <= 1'b0;
	end
	else
	begin
		conv_d_reg <= conv_clock_i;
		// Divides sampled converter edges; only valid well below clk_sys
		if (conv_clock_i & ~conv_d_reg)
			conv_div_reg <= conv_div_reg + 2'h1;
		lock_pin_test_o <= 1'b0;
		lock_pin_o <= 1'b0;
		if (pll_enabled_i)
		begin
			lock_pin_test_o <= (test_code == `SRP_CODE_DIV1) | (test_code == `SRP_CODE_DIV2)
				| (test_code == `SRP_CODE_DIV4); // [R17]
			case (test_code)
				`SRP_CODE_DIV1: lock_pin_o <= conv_clock_i; // [R17]
				`SRP_CODE_DIV2: lock_pin_o <= conv_div_reg[0]; // [R17]
				`SRP_CODE_DIV4: lock_pin_o <= conv_div_reg[1]; // [R17]
				default: lock_pin_o <= 1'b0;
			endcase
		end
	end
end

endmodule // srp_serial_port

/* srp_serial_port_asserts.sv */
// Pin-level checks for the serial register port
`timescale 1ns/10ps
module srp_chk (
	input wire clk_sys_i,
	input wire reset_n_i,
	input wire ser_clk_i,
	input wire frame_enable_n_i,
	input wire ser_data_io_oe_o,
	input wire ser_data_out_o,
	input wire ser_data_out_oe_o,
	input wire [11:0] gain_b_o,
	input wire nco_acc_clear_o,
	input wire four_wire_select_o
);
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!reset_n_i);
	property p_io_mode;
		ser_data_io_oe_o |-> !four_wire_select_o;
	endproperty
	a_io_mode: assert property (p_io_mode) else $error("io pin in 4-pin");
	property p_out_mode;
		ser_data_out_oe_o |-> four_wire_select_o;
	endproperty
	a_out_mode: assert property (p_out_mode) else $error("out pin in 3-pin");
	property p_excl;
		!(ser_data_io_oe_o && ser_data_out_oe_o);
	endproperty
	a_excl: assert property (p_excl) else $error("both pins driven");
	property p_start;
		$rose(ser_data_io_oe_o) |-> !frame_enable_n_i;
	endproperty
	a_start: assert property (p_start) else $error("drive outside frame");
	property p_float;
		frame_enable_n_i [*3] |-> !ser_data_io_oe_o && !ser_data_out_oe_o;
	endproperty
	a_float: assert property (p_float) else $error("no float");
	property p_hold;
		ser_clk_i && $past(ser_clk_i) && $past(ser_data_out_oe_o) |-> $stable(ser_data_out_o);
	endproperty
	a_hold: assert property (p_hold) else $error("data moved on high");
	property p_gain;
		$changed(gain_b_o) |-> ser_clk_i && !frame_enable_n_i;
	endproperty
	a_gain: assert property (p_gain) else $error("gain off a rise");
	property p_nco;
		nco_acc_clear_o |=> !nco_acc_clear_o;
	endproperty
	a_nco: assert property (p_nco) else $error("clear not a pulse");
endmodule // srp_chk
bind srp_serial_port srp_chk u_chk (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
	.ser_clk_i(ser_clk_i), .frame_enable_n_i(frame_enable_n_i), .gain_b_o(gain_b_o),
	.ser_data_io_oe_o(ser_data_io_oe_o), .ser_data_out_o(ser_data_out_o),
	.ser_data_out_oe_o(ser_data_out_oe_o), .nco_acc_clear_o(nco_acc_clear_o),
	.four_wire_select_o(four_wire_select_o));

/* srp_host.sv */
// Host model driving serial register frames
`timescale 1ns/10ps
module srp_host (
	input wire clk_i,
	input wire io_oe_i,
	input wire io_i,
	input wire out_oe_i,
	input wire out_i,
	output reg sck_o = 1'b0,
	output reg sen_n_o = 1'b1,
	output reg sd_o = 1'b0
);
	// Four system clocks a phase, twice the minimum the port needs
	task phase;
		begin
			repeat (4) @(posedge clk_i);
			#1;
		end
	endtask
	task xfer(input [7:0] ins, input [31:0] wd, output [31:0] rd);
		integer i;
		reg [39:0] sh;
		begin
			sh = {ins, wd << (8 * (3 - ins[6:5]))};
			rd = 32'h0;
			sen_n_o = 1'b0;
			for (i = 0; i < 16 + 8 * ins[6:5]; i = i + 1)
			begin
				// Released line toggles so a stale bit never passes
				sd_o = (ins[7] && i > 7) ? ~sd_o : sh[39 - i];
				phase;
				sck_o = 1'b1;
				rd = {rd[30:0], io_oe_i ? io_i : (out_oe_i ? out_i : 1'bx)};
				phase;
				sck_o = 1'b0;
			end
			phase;
			sen_n_o = 1'b1;
			phase;
		end
	endtask
endmodule // srp_host

/* srp_tb.sv */
// Random and corner-case bench for the serial register port
`timescale 1ns/10ps
module tb;
	reg clk_sys_i, reset_n_i, ps, ft, dt, cv, pe, ne;
	reg p1, p2, n1, m1, m2, sl_e, sl_v;
	wire sck, sen_n, sd, io_o, io_oe, so, so_oe, lkt, fw, lk, ml, sl, nc;
	wire [11:0] ga, gb;
	wire [7:0] fc;
	wire [1:0] mp;
	integer err_total, n_tests, cyc, i, k;
	reg [7:0] sh [0:31];
	reg [31:0] r;
	srp_host host (.clk_i(clk_sys_i), .io_oe_i(io_oe), .io_i(io_o), .out_oe_i(so_oe),
		.out_i(so), .sck_o(sck), .sen_n_o(sen_n), .sd_o(sd));
	srp_serial_port dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .ser_clk_i(sck),
		.frame_enable_n_i(sen_n), .ser_data_io_i(io_oe ? io_o : sd), .pll_enabled_i(pe),
		.phase_strobe_i(ps), .nco_sync_enable_i(ne), .full_rate_tick_i(ft),
		.div_clock_tick_i(dt), .conv_clock_i(cv), .ser_data_io_o(io_o),
		.ser_data_io_oe_o(io_oe), .ser_data_out_o(so), .ser_data_out_oe_o(so_oe),
		.gain_a_o(ga), .gain_b_o(gb), .factory_clock_o(fc), .lock_pin_o(lk),
		.lock_pin_test_o(lkt), .mixer_phase_o(mp), .mixer_phase_load_o(ml),
		.strobe_latched_o(sl), .nco_acc_clear_o(nc), .four_wire_select_o(fw));
	function [7:0] rexp(input [4:0] a);
		rexp = (a > 5'h1C) ? 8'h00 : sh[a];
	endfunction
	task chk(input [39:0] nm, input [31:0] e, input [31:0] g);
		begin
			n_tests = n_tests + 1;
			if (g !== e)
			begin
				err_total = err_total + 1;
				$display("unexpected %0s exp %h got %h", nm, e, g);
			end
		end
	endtask
	task wr(input [4:0] a, input [1:0] c, input [31:0] v);
		begin
			// Mirror first, so it already agrees once the frame closes
			for (k = 0; k <= c; k = k + 1)
				sh[a + k] = v[8 * (c - k) +: 8];
			host.xfer({1'b0, c, a}, v, r);
		end
	endtask
	task rd(input [4:0] a, input [1:0] c);
		begin
			host.xfer({1'b1, c, a}, 32'h0, r);
			for (k = 0; k <= c; k = k + 1)
				chk("rdata", rexp(a + k), r[8 * (c - k) +: 8]);
		end
	endtask
	task close_out;
		begin
			$display("checks %0d mismatches %0d", n_tests, err_total);
			if (err_total == 0 && n_tests > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask
	initial
	begin
		clk_sys_i = 1'b0;
		forever #20 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i)
	begin
		#1 {ps, ft, dt, cv, ne} <= $urandom;
		cyc = cyc + 1;
		if (cyc > 20000)
		begin
			err_total = err_total + 1;
			close_out;
		end
	end
	always @(posedge clk_sys_i)
	begin
		p1 <= ps;
		p2 <= p1;
		n1 <= ne;
		m1 <= reset_n_i;
		m2 <= m1;
		if (sh[28][0] ? ft : dt)
			sl_e <= ps;
		if (!reset_n_i || !sen_n)
			sl_v <= 1'b0;
		else if (sh[28][0] ? ft : dt)
			sl_v <= 1'b1;
	end
	always @(negedge clk_sys_i)
		if (m2 && reset_n_i)
		begin
			chk("mload", p1 & ~p2, ml);
			chk("nclr", n1 & p1 & ~p2, nc);
			if (sl_v)
				chk("slat", sl_e, sl);
		end
	initial
	begin
		{reset_n_i, ps, ft, dt, cv} = 5'h00;
		pe = 1'b1;
		ne = 1'b1;
		err_total = 0;
		n_tests = 0;
		cyc = 0;
		i = $urandom(32'hEFB4);
		for (i = 0; i < 32; i = i + 1)
			sh[i] = 8'h00;
		sh[25] = 8'hFF;
		repeat (6) @(posedge clk_sys_i);
		#1 reset_n_i = 1'b1;
		repeat (2) @(posedge clk_sys_i);
		chk("gainb", 12'hF00, gb);
		rd(5'h18, 2'h3);
		rd(5'h1C, 2'h3);
		for (i = 0; i < 4; i = i + 1)
		begin
			wr(5'h18, 2'h3, $urandom);
			rd(5'h18, i[1:0]);
			chk("gainb", {sh[25][3:0], sh[24]}, gb);
			chk("gaina", sh[25][7:4], ga[11:8]);
			chk("fact", sh[26], fc);
			chk("phase", sh[27][2:1], mp);
		end
		wr(5'h1D, 2'h2, $urandom & 32'hFFFFFE);
		rd(5'h1D, 2'h2);
		wr(5'h1C, 2'h0, 32'h1);
		for (i = 0; i < 4; i = i + 1)
		begin
			wr(5'h1B, 2'h0, {5'h1C + i[4:0], 3'h0});
			chk("lock", i > 0, lkt);
			if (i == 0)
				chk("lkpin", 0, lk);
		end
		pe = 1'b0;
		repeat (2) @(posedge clk_sys_i);
		#1 chk("lkoff", 0, lkt);
		chk("lkpin", 0, lk);
		pe = 1'b1;
		wr(5'h00, 2'h0, 32'h1);
		chk("fourw", 1, fw);
		wr(5'h1F, 2'h0, 32'h0);
		chk("fourw", 1, fw);
		rd(5'h00, 2'h0);
		rd(5'h18, 2'h1);
		close_out;
	end
endmodule // tb
